// ---- verilog/lcfs_pkg.sv ----
// shared constants and types for the led channel fault supervisor
package lcfs_pkg;
  localparam int NCH     = 8;
  localparam int PCLK_NS = 50;
  // startup pin check settle, loop-exclusion wait, open/short classify settle
  localparam int STARTUP_NS = 10000;
  localparam int EXCL_NS    = 2000;
  localparam int CLASS_NS   = 1000;
  localparam logic [7:0] STARTUP_CYC = 8'((STARTUP_NS + PCLK_NS - 1) / PCLK_NS);
  localparam logic [7:0] EXCL_CYC    = 8'((EXCL_NS + PCLK_NS - 1) / PCLK_NS);
  localparam logic [7:0] CLASS_CYC   = 8'((CLASS_NS + PCLK_NS - 1) / PCLK_NS);

  localparam int AW = 12;
  localparam logic [AW-1:0] CTRL_OFF     = 12'h000;
  localparam logic [AW-1:0] THR_OFF      = 12'h004;
  localparam logic [AW-1:0] STAT_OFF     = 12'h008;
  localparam logic [AW-1:0] IRQ_STAT_OFF = 12'h00c;
  localparam logic [AW-1:0] IRQ_MASK_OFF = 12'h010;

  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_CHEN_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000ff01;
  localparam logic [31:0] THR_RST  = 32'h88888888;
  localparam int STAT_FAULT_BIT = 2;
  localparam int STAT_OPEN_LSB  = 8;
  localparam int STAT_SS_LSB    = 16;

  localparam int IRQ_W       = 4;
  localparam int IRQ_STARTUP = 0;
  localparam int IRQ_RUNGND  = 1;
  localparam int IRQ_OPEN    = 2;
  localparam int IRQ_SS      = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [1:0] {DEV_OFF, DEV_CHECK, DEV_RUN, DEV_LATCH} lcfs_dev_e;
  typedef enum logic [2:0] {CH_IDLE, CH_ON, CH_EXCL, CH_CLASS, CH_OPEN, CH_GND,
                            CH_SSOFF} lcfs_ch_e;

  // comparator results and enable pin, all asynchronous to pclk
  typedef struct packed {
    logic           en;
    logic           ovp;
    logic [NCH-1:0] over_thr;
    logic [NCH-1:0] in_reg;
    logic [NCH-1:0] gnd;
  } lcfs_ana_s;
  localparam int SYNC_W = $bits(lcfs_ana_s);

  // controls toward the current sinks and boost loop
  typedef struct packed {
    logic [NCH-1:0] drive_en;
    logic [NCH-1:0] in_loop;
    logic           chk_bias;
    logic [31:0]    thr_code;
  } lcfs_drv_s;

  typedef struct packed {
    logic [SYNC_W-1:0] m;
    logic [SYNC_W-1:0] q;
  } lcfs_sync_s;

  typedef struct packed {
    lcfs_ch_e   st;
    logic [7:0] cnt;
  } lcfs_ch_s;

  typedef struct packed {
    lcfs_dev_e        st;
    logic [7:0]       cnt;
    logic [31:0]      ctrl;
    logic [31:0]      thr;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      prdata;
    logic             pslverr;
  } lcfs_top_s;
endpackage : lcfs_pkg

// ---- verilog/lcfs_sync.sv ----
// two-flop synchroniser for all comparator and pin inputs
`timescale 1ns/100ps
module lcfs_sync
  import lcfs_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // asynchronous in, synchronous out
  input  wire logic [SYNC_W-1:0] d,
  output logic      [SYNC_W-1:0] q
);
  lcfs_sync_s r, n;

  always_comb begin
    n   = r;
    n.m = d;
    n.q = r.m;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= '0;
    else if (ce) r <= n;
  end

  assign q = r.q;
endmodule : lcfs_sync

// ---- verilog/lcfs_chan.sv ----
// per-channel fault sequencer: operating pin fault and string short
`timescale 1ns/100ps
module lcfs_chan
  import lcfs_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // control
  input  wire logic run,
  input  wire logic pwm_start,
  input  wire logic auto_rst,
  // synchronised comparators
  input  wire logic ovp,
  input  wire logic in_reg,
  input  wire logic gnd,
  input  wire logic over_thr,
  // outputs
  output logic      drive_en,
  output logic      in_loop,
  output logic      is_open,
  output logic      is_gnd,
  output logic      is_ss,
  output logic      ev_open,
  output logic      ev_gnd,
  output logic      ev_ss
);
  lcfs_ch_s r, n;

  always_comb begin
    n = r;
    if (!run) n.st = CH_IDLE;
    else case (r.st)
      CH_IDLE: n.st = CH_ON;
      CH_ON: begin
        if (over_thr) n.st = CH_SSOFF;
        else if (!in_reg && ovp) begin
          n.st  = CH_EXCL;
          n.cnt = EXCL_CYC - 8'h01;
        end
      end
      CH_EXCL: begin
        // out of the loop but still sinking, so the raised output can bleed down
        if (r.cnt == 8'h00) begin
          n.st  = CH_CLASS;
          n.cnt = CLASS_CYC - 8'h01;
        end else n.cnt = r.cnt - 8'h01;
      end
      CH_CLASS: begin
        if (r.cnt == 8'h00) n.st = gnd ? CH_GND : CH_OPEN;
        else n.cnt = r.cnt - 8'h01;
      end
      CH_SSOFF: if (pwm_start && auto_rst && !over_thr) n.st = CH_ON;
      CH_OPEN, CH_GND: n.st = r.st;
      default: n.st = CH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= '{st: CH_IDLE, cnt: 8'h00};
    else if (ce) r <= n;
  end

  assign drive_en = (r.st == CH_ON) || (r.st == CH_EXCL);
  assign in_loop  = (r.st == CH_ON);
  assign is_open  = (r.st == CH_OPEN);
  assign is_gnd   = (r.st == CH_GND);
  assign is_ss    = (r.st == CH_SSOFF);
  assign ev_open  = ce && (r.st == CH_CLASS) && (n.st == CH_OPEN);
  assign ev_gnd   = ce && (r.st == CH_CLASS) && (n.st == CH_GND);
  assign ev_ss    = ce && (r.st == CH_ON) && (n.st == CH_SSOFF);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence s_trip;
    run && in_loop && !over_thr && !in_reg && ovp;
  endsequence
  a_trip_excludes: assert property (s_trip |=> !in_loop && drive_en)
    else $error("pin fault did not leave the loop");
  a_excl_then_off: assert property (s_trip ##1 run [*8] |-> drive_en)
    else $error("channel disabled before the exclusion wait");
  a_off_after_excl: assert property ($rose(r.st == CH_CLASS) |-> !drive_en)
    else $error("channel still driving while classifying");
  a_open_keeps_off: assert property (is_open && run |=> is_open && !drive_en)
    else $error("open channel came back");
  a_ss_off_now: assert property (run && in_loop && over_thr |=> !drive_en && is_ss)
    else $error("string short did not disable the channel");
  a_no_auto_restart: assert property (is_ss && run && !auto_rst |=> is_ss)
    else $error("string short restarted with auto restart off");
  a_restart_on_pwm: assert property (is_ss && run && auto_rst && pwm_start && !over_thr
                                     |=> drive_en)
    else $error("cleared string short not re-enabled");
endmodule : lcfs_chan

// ---- verilog/lcfs_top.sv ----
// led channel fault supervisor with apb registers and interrupt
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module lcfs_top
  import lcfs_pkg::*;
(
  // clock, reset, enable
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // analog side
  input  wire lcfs_ana_s     ana,
  input  wire logic          pwm_start,
  output lcfs_drv_s          drv,
  // status
  output logic               fault_flag,
  output logic               shutdown,
  output logic               irq
);
  lcfs_top_s r, n;
  lcfs_ana_s s;
  logic [SYNC_W-1:0] s_vec;
  logic [NCH-1:0] run_v, c_drv, c_loop, c_open, c_gnd, c_ss, e_open, e_gnd, e_ss;
  logic [IRQ_W-1:0] ev;
  logic setup, access, mapped;

  function automatic logic is_mapped(input logic [AW-1:0] a);
    return (a == CTRL_OFF) || (a == THR_OFF) || (a == STAT_OFF) ||
           (a == IRQ_STAT_OFF) || (a == IRQ_MASK_OFF);
  endfunction : is_mapped

  lcfs_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (ana),
    .q       (s_vec)
  );
  assign s = lcfs_ana_s'(s_vec);

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign run_v[i] = (r.st == DEV_RUN) && r.ctrl[CTRL_CHEN_LSB + i];
    lcfs_chan u_ch (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .run       (run_v[i]),
      .pwm_start (pwm_start),
      .auto_rst  (r.ctrl[CTRL_AUTO_BIT]),
      .ovp       (s.ovp),
      .in_reg    (s.in_reg[i]),
      .gnd       (s.gnd[i]),
      .over_thr  (s.over_thr[i]),
      .drive_en  (c_drv[i]),
      .in_loop   (c_loop[i]),
      .is_open   (c_open[i]),
      .is_gnd    (c_gnd[i]),
      .is_ss     (c_ss[i]),
      .ev_open   (e_open[i]),
      .ev_gnd    (e_gnd[i]),
      .ev_ss     (e_ss[i])
    );
  end

  assign setup  = psel && !penable;
  assign access = psel && penable && ce;
  assign mapped = is_mapped(paddr);

  always_comb begin
    n  = r;
    ev = '0;
    // device sequencing
    case (r.st)
      DEV_OFF: begin
        if (s.en) begin
          n.st  = DEV_CHECK;
          n.cnt = STARTUP_CYC - 8'h01;
        end
      end
      DEV_CHECK: begin
        if (!s.en) n.st = DEV_OFF;
        else if (r.cnt != 8'h00) n.cnt = r.cnt - 8'h01;
        else if (|(s.gnd & r.ctrl[CTRL_CHEN_LSB +: NCH])) begin
          n.st = DEV_LATCH;
          ev[IRQ_STARTUP] = 1'b1;
        end else n.st = DEV_RUN;
      end
      DEV_RUN: begin
        if (!s.en) n.st = DEV_OFF;
        else if (|c_gnd) begin
          n.st = DEV_LATCH;
          ev[IRQ_RUNGND] = 1'b1;
        end
      end
      DEV_LATCH: if (!s.en) n.st = DEV_OFF;
      default: n.st = DEV_OFF;
    endcase
    ev[IRQ_OPEN] = |e_open;
    ev[IRQ_SS]   = |e_ss;

    // register read, captured in the setup cycle so prdata is a flop
    if (setup) begin
      n.pslverr = !mapped;
      n.prdata  = 32'h0;
      case (paddr)
        CTRL_OFF:     n.prdata = r.ctrl;
        THR_OFF:      n.prdata = r.thr;
        STAT_OFF: begin
          n.prdata[1:0]                       = r.st;
          n.prdata[STAT_FAULT_BIT]            = fault_flag;
          n.prdata[STAT_OPEN_LSB +: NCH]      = c_open;
          n.prdata[STAT_SS_LSB +: NCH]        = c_ss;
        end
        IRQ_STAT_OFF: n.prdata[IRQ_W-1:0]     = r.irq_st;
        IRQ_MASK_OFF: n.prdata[IRQ_W-1:0]     = r.irq_mask;
        default:      n.prdata = 32'h0;
      endcase
    end

    // register write; unmapped and status writes are dropped
    if (access && pwrite) begin
      case (paddr)
        CTRL_OFF:     n.ctrl     = pwdata;
        THR_OFF:      n.thr      = pwdata;
        IRQ_STAT_OFF: n.irq_st   = r.irq_st & ~pwdata[IRQ_W-1:0];
        IRQ_MASK_OFF: n.irq_mask = pwdata[IRQ_W-1:0];
        default:      n.ctrl     = n.ctrl;
      endcase
    end
    // a new event beats a same-cycle clear
    n.irq_st = n.irq_st | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: DEV_OFF, cnt: 8'h00, ctrl: CTRL_RST, thr: THR_RST, irq_st: '0,
             irq_mask: IRQ_MASK_RST, prdata: 32'h0, pslverr: 1'b0};
    end else if (ce) begin
      r <= n;
    end
  end

  // bus answers
  assign pready  = access;
  assign prdata  = r.prdata;
  assign pslverr = r.pslverr && access;

  // analog controls
  assign drv.drive_en = c_drv;
  assign drv.in_loop  = c_loop;
  assign drv.chk_bias = (r.st == DEV_CHECK);
  assign drv.thr_code = r.thr;

  assign shutdown   = (r.st == DEV_LATCH);
  assign fault_flag = shutdown || (|c_open) || (|c_ss);
  assign irq        = |(r.irq_st & r.irq_mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  a_startup_latch: assert property (r.st == DEV_CHECK && r.cnt == 8'h00 && s.en &&
      |(s.gnd & r.ctrl[CTRL_CHEN_LSB +: NCH]) |=> shutdown && fault_flag && drv.drive_en == '0)
    else $error("startup short did not latch");
  a_no_drive_check: assert property (r.st == DEV_CHECK |-> drv.drive_en == '0)
    else $error("channel driven during startup check");
  a_gnd_shutdown: assert property (r.st == DEV_RUN && s.en && |c_gnd |=> shutdown ##1
      drv.drive_en == '0)
    else $error("grounded pin did not shut down");
  a_latch_holds: assert property (shutdown && s.en |=> shutdown)
    else $error("latched shutdown released without enable toggle");
  a_en_clears: assert property (shutdown && !s.en |=> r.st == DEV_OFF)
    else $error("enable low did not clear the latch");
  a_sync_depth: assert property (ce [*3] |-> s.en == $past(ana.en, 2))
    else $error("enable not passed through two flops");
  a_irq_level: assert property (irq == |(r.irq_st & r.irq_mask))
    else $error("interrupt output disagrees with status and mask");
  a_irq_sticky: assert property (r.irq_st[IRQ_SS] && !(access && pwrite) |=> r.irq_st[IRQ_SS])
    else $error("status bit lost without a clear");
endmodule : lcfs_top

// ---- dv/lcfs_sinks_model.sv ----
// behavioural led sinks and boost stage facing the supervisor
`timescale 1ns/100ps
module lcfs_sinks_model
  import lcfs_pkg::*;
(
  // supervisor side
  input  wire lcfs_drv_s      drv,
  input  wire logic           en,
  // injected pin faults
  input  wire logic [NCH-1:0] open_f,
  input  wire logic [NCH-1:0] gnd_f,
  input  wire logic [NCH-1:0] ss_f,
  // comparator results
  output lcfs_ana_s           ana
);
  logic [NCH-1:0] reg_ok;
  // a sink regulates only when driven and its pin is whole
  assign reg_ok       = drv.drive_en & ~open_f & ~gnd_f;
  assign ana.en       = en;
  // boost climbs to overvoltage while any loop channel cannot regulate
  assign ana.ovp      = |(drv.in_loop & ~reg_ok);
  assign ana.in_reg   = reg_ok;
  // a grounded pin reads low whatever the bias, so the check sees it always
  assign ana.gnd      = gnd_f;
  assign ana.over_thr = ss_f;
endmodule : lcfs_sinks_model

// ---- dv/lcfs_top_bench.sv ----
// self-checking bench for the led channel fault supervisor
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module lcfs_top_bench
  import lcfs_pkg::*;
;
  logic           pclk = 0, presetn = 0, ce = 1;
  logic           psel = 0, penable = 0, pwrite = 0, pwm_start = 0, en = 0;
  logic [AW-1:0]  paddr = '0;
  logic [31:0]    pwdata = '0, prdata, rd;
  logic           pready, pslverr, fault_flag, shutdown, irq, er;
  logic [NCH-1:0] open_f = '0, gnd_f = '0, ss_f = '0;
  lcfs_ana_s      ana;
  lcfs_drv_s      drv;
  int             n_errors = 0, n_checks = 0, cyc = 0;

  always #25 pclk = ~pclk;

  lcfs_top lcfs_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ana(ana), .pwm_start(pwm_start), .drv(drv),
    .fault_flag(fault_flag), .shutdown(shutdown), .irq(irq));
  lcfs_sinks_model lcfs_sinks_model_i (.drv(drv), .en(en), .open_f(open_f),
    .gnd_f(gnd_f), .ss_f(ss_f), .ana(ana));

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // the run should end well inside 20000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdm(input string nm, input logic [AW-1:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask : rdm

  // polls the state field; the startup check alone takes 200 cycles
  task automatic wait_st(input logic [1:0] s);
    int k;
    k = 0;
    do begin
      apb(1'b0, STAT_OFF, 32'h0);
      k++;
    end while (rd[1:0] !== s && k < 150);
    `CHK("state", s, rd[1:0])
  endtask : wait_st

  task automatic pwm();
    @(posedge pclk);
    pwm_start <= 1'b1;
    @(posedge pclk);
    pwm_start <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : pwm

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("thr_code", THR_RST, drv.thr_code)
    rdm("ctrl", CTRL_OFF, '1, CTRL_RST);
    rdm("thr", THR_OFF, '1, THR_RST);
    rdm("mask", IRQ_MASK_OFF, '1, 32'(IRQ_MASK_RST));
    rdm("unmapped", 12'h100, '1, 32'h0);
    `CHK("pslverr", 1'b1, er)
    en <= 1'b1;
    wait_st(2'h2);
    repeat (3) @(posedge pclk);
    `CHK("drive_en", 8'hff, drv.drive_en)
    // string short on channel 3, only that sink drops
    ss_f[3] <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("drive_en", 8'hf7, drv.drive_en)
    rdm("stat", STAT_OFF, 32'h00ff0004, 32'h00080004);
    apb(1'b1, IRQ_MASK_OFF, 32'h8);
    @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    pwm();
    `CHK("drive_en", 8'hf7, drv.drive_en)
    ss_f[3] <= 1'b0;
    repeat (4) @(posedge pclk);
    pwm();
    `CHK("drive_en", 8'hff, drv.drive_en)
    apb(1'b1, IRQ_STAT_OFF, 32'h8);
    @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    // with auto restart off the channel must wait for the bit
    apb(1'b1, CTRL_OFF, 32'h0000ff00);
    ss_f[3] <= 1'b1;
    repeat (6) @(posedge pclk);
    ss_f[3] <= 1'b0;
    repeat (4) @(posedge pclk);
    pwm();
    `CHK("drive_en", 8'hf7, drv.drive_en)
    apb(1'b1, CTRL_OFF, CTRL_RST);
    pwm();
    `CHK("drive_en", 8'hff, drv.drive_en)
    // open pin: leaves the loop before its sink is switched off
    open_f[5] <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("in_loop", 1'b0, drv.in_loop[5])
    `CHK("drive_en", 1'b1, drv.drive_en[5])
    repeat (80) @(posedge pclk);
    `CHK("drive_en", 8'hdf, drv.drive_en)
    rdm("stat", STAT_OFF, 32'h00ffff07, 32'h00002006);
    `CHK("shutdown", 1'b0, shutdown)
    // grounded pin in run latches the part off
    gnd_f[1] <= 1'b1;
    repeat (90) @(posedge pclk);
    `CHK("shutdown", 1'b1, shutdown)
    `CHK("drive_en", 8'h00, drv.drive_en)
    pwm();
    rdm("stat", STAT_OFF, 32'h7, 32'h7);
    en <= 1'b0;
    gnd_f[1] <= 1'b0;
    open_f[5] <= 1'b0;
    repeat (6) @(posedge pclk);
    en <= 1'b1;
    wait_st(2'h2);
    repeat (3) @(posedge pclk);
    `CHK("drive_en", 8'hff, drv.drive_en)
    // clock enable low freezes the channels even with a short present
    ce <= 1'b0;
    ss_f[3] <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("drive_en", 8'hff, drv.drive_en)
    ce <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("drive_en", 8'hf7, drv.drive_en)
    ss_f[3] <= 1'b0;
    // short found by the power-up check
    en <= 1'b0;
    repeat (6) @(posedge pclk);
    gnd_f[2] <= 1'b1;
    en <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK("chk_bias", 1'b1, drv.chk_bias)
    wait_st(2'h3);
    `CHK("chk_bias", 1'b0, drv.chk_bias)
    `CHK("fault_flag", 1'b1, fault_flag)
    `CHK("drive_en", 8'h00, drv.drive_en)
    rdm("irq_st", IRQ_STAT_OFF, 32'h1, 32'h1);
    finish_test();
  end
endmodule : lcfs_top_bench
